// File: rtl/dcia_core.sv
`timescale 1ns/1ps
`default_nettype none
module dcia_core #(
  parameter int AW = 10
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // variable access from the track decoder
  input wire logic i_cv_wr,
  input wire logic i_cv_rd,
  input wire logic [AW-1:0] i_cv_num,
  input wire logic [7:0] i_cv_wdata,
  output logic [7:0] o_cv_rdata,
  output logic o_cv_rvalid,
  // operating command from the track decoder
  input wire logic i_cmd_valid,
  input wire logic i_cmd_alt,
  input wire logic i_cmd_long,
  input wire logic [13:0] i_cmd_addr,
  input wire dcia_pkg::dcia_kind_t i_cmd_kind,
  // address decision
  output logic o_cmd_hit,
  output logic o_speed_take,
  output logic o_func_take,
  output logic [1:0] o_func_bank,
  output logic o_long_mode,
  output logic [13:0] o_dcc_addr
);
  import dcia_pkg::*;

  logic [7:0] short_reg;
  logic [7:0] long_hi_reg;
  logic [7:0] long_lo_reg;
  logic [7:0] config_reg;
  logic [7:0] consec_reg;
  logic [7:0] tgt_hund_reg;
  logic [7:0] tgt_ut_reg;
  logic [7:0] val_hund_reg;
  dcia_ind_t ind_reg;
  dcia_ind_t ind_next;
  logic [9:0] target;
  logic [9:0] value;
  logic trig;
  logic ind_ok;
  logic wr_en;
  logic [AW-1:0] wr_num;
  logic [7:0] wr_data;
  logic [7:0] mem_rdata;
  logic [13:0] long_addr;
  logic long_ok;
  logic short_ok;
  logic [1:0] consec_cnt;
  logic [13:0] alt_off;
  logic alt_hit;
  logic dcc_hit;

  // computed target and value of an indirect write
  assign target = 10'(tgt_hund_reg) * DEC_HUNDRED + 10'(tgt_ut_reg);
  assign value = (ind_reg == DCIA_VAL)
    ? 10'(val_hund_reg) * DEC_HUNDRED + 10'(i_cv_wdata)
    : 10'(i_cv_wdata);
  // the copy fires on the value write, so the station must send it last
  assign trig = i_cv_wr && (i_cv_num == AW'(CV_VAL_TRIG));
  // a wrong target or an oversize value drops the copy
  assign ind_ok = (target != 10'h000) && (value <= VALUE_MAX)
    && (target < CV_TGT_HUND || target > CV_VAL_TRIG)
    && (ind_reg == DCIA_IDLE || ind_reg == DCIA_ADDR
        || i_cv_wdata <= UT_MAX);

  // one write path for direct and indirect writes
  always_comb begin
    wr_en = 1'b0;
    wr_num = i_cv_num;
    wr_data = i_cv_wdata;
    if (trig) begin
      wr_en = ind_ok;
      wr_num = AW'(target);
      wr_data = value[7:0];
    end else if (i_cv_wr && (i_cv_num < AW'(CV_TGT_HUND)
                 || i_cv_num > AW'(CV_VAL_TRIG))) begin
      wr_en = 1'b1;
    end
  end

  // indirect sequence progress; value hundreds marks four-helper use
  always_comb begin
    ind_next = ind_reg;
    if (trig) begin
      ind_next = DCIA_IDLE;
    end else if (i_cv_wr && i_cv_num == AW'(CV_VAL_HUND)
                 && i_cv_wdata <= HUND_MAX) begin
      ind_next = DCIA_VAL;
    end else if (i_cv_wr && ind_reg == DCIA_IDLE
                 && (i_cv_num == AW'(CV_TGT_HUND)
                     || i_cv_num == AW'(CV_TGT_UT))) begin
      ind_next = DCIA_ADDR;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ind_reg <= DCIA_IDLE;
    end else begin
      ind_reg <= ind_next;
    end
  end

  // helper variables; out-of-range writes are refused
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      tgt_hund_reg <= 8'h00;
      tgt_ut_reg <= 8'h00;
      val_hund_reg <= 8'h00;
    end else if (trig) begin
      tgt_hund_reg <= 8'h00;
      tgt_ut_reg <= 8'h00;
      val_hund_reg <= 8'h00;
    end else if (i_cv_wr) begin
      if (i_cv_num == AW'(CV_TGT_HUND) && i_cv_wdata <= HUND_MAX) begin
        tgt_hund_reg <= i_cv_wdata;
      end else if (i_cv_num == AW'(CV_TGT_UT) && i_cv_wdata <= UT_MAX) begin
        tgt_ut_reg <= i_cv_wdata;
      end else if (i_cv_num == AW'(CV_VAL_HUND) && i_cv_wdata <= HUND_MAX) begin
        val_hund_reg <= i_cv_wdata;
      end
    end
  end

  // shadows of the addressing variables, fed by the shared write path
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      short_reg <= RST_SHORT;
      long_hi_reg <= RST_LONG_HI;
      long_lo_reg <= RST_LONG_LO;
      config_reg <= RST_CONFIG;
      consec_reg <= RST_CONSEC;
    end else if (wr_en) begin
      if (wr_num == AW'(CV_SHORT) && wr_data != 8'h00) begin
        short_reg <= wr_data;
      end else if (wr_num == AW'(CV_LONG_HI)) begin
        long_hi_reg <= wr_data;
      end else if (wr_num == AW'(CV_LONG_LO)) begin
        long_lo_reg <= wr_data;
      end else if (wr_num == AW'(CV_CONFIG)) begin
        config_reg <= wr_data;
      end else if (wr_num == AW'(CV_CONSEC)) begin
        consec_reg <= wr_data;
      end
    end
  end

  dcia_cv_mem #(
    .AW(AW),
    .DW(8)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(wr_en),
    .i_waddr(wr_num),
    .i_wdata(wr_data),
    .i_raddr(i_cv_num),
    .o_rdata(mem_rdata)
  );

  // read path: first stage picks helper or shadow, second registers data
  logic rd_p1_reg;
  logic rd_sel_reg;
  logic [7:0] rd_side_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_p1_reg <= 1'b0;
      rd_sel_reg <= 1'b0;
      rd_side_reg <= 8'h00;
    end else begin
      rd_p1_reg <= i_cv_rd;
      rd_sel_reg <= 1'b1;
      if (i_cv_num == AW'(CV_TGT_HUND)) begin
        rd_side_reg <= tgt_hund_reg;
      end else if (i_cv_num == AW'(CV_TGT_UT)) begin
        rd_side_reg <= tgt_ut_reg;
      end else if (i_cv_num == AW'(CV_VAL_HUND)) begin
        rd_side_reg <= val_hund_reg;
      end else if (i_cv_num == AW'(CV_VAL_TRIG)) begin
        rd_side_reg <= 8'h00; // value helper never holds data after a write
      end else if (i_cv_num == AW'(CV_SHORT)) begin
        rd_side_reg <= short_reg;
      end else if (i_cv_num == AW'(CV_LONG_HI)) begin
        rd_side_reg <= long_hi_reg;
      end else if (i_cv_num == AW'(CV_LONG_LO)) begin
        rd_side_reg <= long_lo_reg;
      end else if (i_cv_num == AW'(CV_CONFIG)) begin
        rd_side_reg <= config_reg;
      end else if (i_cv_num == AW'(CV_CONSEC)) begin
        rd_side_reg <= consec_reg;
      end else begin
        rd_sel_reg <= 1'b0;
        rd_side_reg <= 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cv_rvalid <= 1'b0;
      o_cv_rdata <= 8'h00;
    end else begin
      o_cv_rvalid <= rd_p1_reg;
      if (rd_p1_reg) begin
        o_cv_rdata <= rd_sel_reg ? rd_side_reg : mem_rdata;
      end
    end
  end

  // address selection; the top two bits of the high byte are format marks
  assign long_addr = {long_hi_reg[5:0], long_lo_reg};
  assign long_ok = long_addr >= LONG_MIN && long_addr <= LONG_MAX;
  assign short_ok = short_reg <= SHORT_MAX;
  // only one of the two addresses is ever compared
  always_comb begin
    dcc_hit = 1'b0;
    if (config_reg[CFG_LONG_BIT]) begin
      dcc_hit = i_cmd_long && long_ok && i_cmd_addr == long_addr;
    end else begin
      dcc_hit = !i_cmd_long && short_ok
        && i_cmd_addr == 14'(short_reg);
    end
  end

  // consecutive count: bits are apart for compatibility
  always_comb begin
    case ({consec_reg[CONSEC_HI_BIT], consec_reg[CONSEC_LO_BIT]})
      2'b01: consec_cnt = 2'h1;
      2'b10: consec_cnt = 2'h2;
      2'b11: consec_cnt = 2'h3;
      default: consec_cnt = 2'h0;
    endcase
  end

  // alternate format shares variable 1 and runs alongside the other one
  assign alt_off = i_cmd_addr - 14'(short_reg);
  assign alt_hit = i_cmd_addr >= 14'(short_reg)
    && alt_off <= 14'(consec_cnt);

  // hit, speed and func outputs are one-cycle pulses after the command; the bank holds its value
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmd_hit <= 1'b0;
      o_speed_take <= 1'b0;
      o_func_take <= 1'b0;
      o_func_bank <= 2'h0;
    end else begin
      o_cmd_hit <= 1'b0;
      o_speed_take <= 1'b0;
      o_func_take <= 1'b0;
      if (i_cmd_valid && i_cmd_alt && alt_hit) begin
        o_cmd_hit <= 1'b1;
        o_func_bank <= alt_off[1:0];
        o_speed_take <= i_cmd_kind == DCIA_K_SPEED
          && alt_off == 14'h0000;
        o_func_take <= i_cmd_kind == DCIA_K_FUNC;
      end else if (i_cmd_valid && !i_cmd_alt && dcc_hit) begin
        o_cmd_hit <= 1'b1;
        o_func_bank <= 2'h0;
        o_speed_take <= i_cmd_kind == DCIA_K_SPEED;
        o_func_take <= i_cmd_kind == DCIA_K_FUNC;
      end
    end
  end

  // address in force for the packet format, from registers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_long_mode <= 1'b0;
      o_dcc_addr <= 14'h0000;
    end else begin
      o_long_mode <= config_reg[CFG_LONG_BIT];
      o_dcc_addr <= config_reg[CFG_LONG_BIT] ? long_addr : 14'(short_reg);
    end
  end

  a_ind_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    trig |=> tgt_hund_reg == 8'h00 && tgt_ut_reg == 8'h00
      && val_hund_reg == 8'h00 && ind_reg == DCIA_IDLE)
    else $error("helpers not cleared after copy");
  a_hund_range: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    tgt_hund_reg <= HUND_MAX && val_hund_reg <= HUND_MAX)
    else $error("hundreds helper out of range");
  a_ut_range: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_cv_wr && i_cv_num == AW'(CV_TGT_UT) && i_cv_wdata > UT_MAX && !trig
      |=> $stable(tgt_ut_reg))
    else $error("units helper took a bad value");
  a_ind_target: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    trig && ind_ok |-> wr_en && wr_num == AW'(target)
      && 10'(wr_data) == value)
    else $error("indirect copy went astray");
  a_four_value: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    trig && ind_reg == DCIA_VAL && ind_ok |-> 10'(wr_data)
      == 10'(val_hund_reg) * DEC_HUNDRED + 10'(i_cv_wdata))
    else $error("four-helper value wrong");
  a_bad_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    trig && value > VALUE_MAX |-> !wr_en)
    else $error("oversize value written");
  a_bad_target: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    trig && (target == 10'h000 || (target >= CV_TGT_HUND && target <= CV_VAL_TRIG))
      |-> !wr_en)
    else $error("copy into a helper or variable zero");
  a_short_only: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_cmd_valid && !i_cmd_alt && i_cmd_long && !config_reg[CFG_LONG_BIT]
      |=> !o_cmd_hit)
    else $error("long address answered in short mode");
  a_long_range: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_cmd_valid && !i_cmd_alt && config_reg[CFG_LONG_BIT]
      && (i_cmd_addr < LONG_MIN || i_cmd_addr > LONG_MAX) |=> !o_cmd_hit)
    else $error("long address out of range answered");
  a_speed_base: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_speed_take |-> o_func_bank == 2'h0)
    else $error("speed taken on consecutive address");
  a_consec_dcc: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_cmd_valid && !i_cmd_alt && !i_cmd_long && !config_reg[CFG_LONG_BIT]
      && i_cmd_addr == 14'(short_reg) + 14'h0001 |=> !o_cmd_hit)
    else $error("consecutive address answered under DCC");
  a_consec_cnt: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_cmd_valid && i_cmd_alt && i_cmd_addr == 14'(short_reg) + 14'h0003
      && consec_cnt != 2'h3 |=> !o_cmd_hit)
    else $error("disabled consecutive address answered");
  a_read_lat: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_cv_rd |-> ##2 o_cv_rvalid)
    else $error("read answer late");
endmodule : dcia_core
`default_nettype wire

// File: rtl/dcia_cv_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dcia_cv_mem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // clock
  input wire logic i_clk_sys,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // read port
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents are kept values, not control state
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // registered read, old data on a same-cycle write
  always_ff @(posedge i_clk_sys) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : dcia_cv_mem
`default_nettype wire

// File: rtl/dcia_pkg.sv
package dcia_pkg;
  // configuration variable numbers
  localparam logic [9:0] CV_SHORT = 10'h001;
  localparam logic [9:0] CV_LONG_HI = 10'h011;
  localparam logic [9:0] CV_LONG_LO = 10'h012;
  localparam logic [9:0] CV_CONFIG = 10'h01d;
  localparam logic [9:0] CV_CONSEC = 10'h031;
  localparam logic [9:0] CV_TGT_HUND = 10'h060;
  localparam logic [9:0] CV_TGT_UT = 10'h061;
  localparam logic [9:0] CV_VAL_HUND = 10'h062;
  localparam logic [9:0] CV_VAL_TRIG = 10'h063;
  // field positions
  localparam int CFG_LONG_BIT = 5;
  localparam int CONSEC_LO_BIT = 3;
  localparam int CONSEC_HI_BIT = 7;
  // values after reset
  localparam logic [7:0] RST_SHORT = 8'h03;
  localparam logic [7:0] RST_LONG_HI = 8'hc0;
  localparam logic [7:0] RST_LONG_LO = 8'h80;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_CONSEC = 8'h01;
  // ranges
  localparam logic [7:0] HUND_MAX = 8'h09;
  localparam logic [7:0] UT_MAX = 8'h63;
  localparam logic [7:0] SHORT_MAX = 8'h7f;
  localparam logic [13:0] LONG_MIN = 14'h0080;
  localparam logic [13:0] LONG_MAX = 14'h27ff;
  localparam logic [9:0] VALUE_MAX = 10'h0ff;
  localparam logic [9:0] DEC_HUNDRED = 10'h064;
  localparam logic [1:0] RD_LATENCY = 2'h2;
  // indirect write progress, gray coded
  typedef enum logic [1:0] {
    DCIA_IDLE = 2'b00,
    DCIA_ADDR = 2'b01,
    DCIA_VAL = 2'b11
  } dcia_ind_t;
  // kind of operating command
  typedef enum logic [1:0] {
    DCIA_K_SPEED = 2'b00,
    DCIA_K_FUNC = 2'b01,
    DCIA_K_OTHER = 2'b11
  } dcia_kind_t;
endpackage : dcia_pkg

// File: tb/dcia_station.sv
`timescale 1ns/1ps
`default_nettype none
// command station stand-in: one request per wr, rd or cmd task, strobes held over the taking edge
module dcia_station (
  // clock
  input wire logic i_clk_sys,
  // variable access
  output logic o_cv_wr,
  output logic o_cv_rd,
  output logic [9:0] o_cv_num,
  output logic [7:0] o_cv_wdata,
  input wire logic [7:0] i_cv_rdata,
  input wire logic i_cv_rvalid,
  // operating commands and the decoder's decision {hit, speed, func, bank}
  output logic o_cmd_valid,
  output logic o_cmd_alt,
  output logic o_cmd_long,
  output logic [13:0] o_cmd_addr,
  output dcia_pkg::dcia_kind_t o_cmd_kind,
  input wire logic [4:0] i_cmd_resp
);
  import dcia_pkg::*;
  // idle bus at time zero
  initial begin
    o_cv_wr = 1'b0;
    o_cv_rd = 1'b0;
    o_cv_num = 10'h0;
    o_cv_wdata = 8'h0;
    o_cmd_valid = 1'b0;
    o_cmd_alt = 1'b0;
    o_cmd_long = 1'b0;
    o_cmd_addr = 14'h0;
    o_cmd_kind = DCIA_K_OTHER;
  end
  // released lines show the inverse so stale values never pass for good ones
  task automatic wr(input logic [9:0] n, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_cv_wr <= 1'b1;
    o_cv_num <= n;
    o_cv_wdata <= d;
    @(posedge i_clk_sys);
    o_cv_wr <= 1'b0;
    o_cv_num <= ~n;
    o_cv_wdata <= ~d;
  endtask : wr
  // read with bounded wait; lat counts edges after the taking edge
  task automatic rd(input logic [9:0] n, output logic [7:0] d, output logic [3:0] lat);
    @(posedge i_clk_sys);
    o_cv_rd <= 1'b1;
    o_cv_num <= n;
    @(posedge i_clk_sys);
    o_cv_rd <= 1'b0;
    o_cv_num <= ~n;
    d = 8'hxx;
    lat = 4'hf;
    for (int k = 1; k < 6 && lat == 4'hf; k++) begin
      @(posedge i_clk_sys);
      if (i_cv_rvalid === 1'b1) begin
        d = i_cv_rdata;
        lat = 4'(k);
      end
    end
  endtask : rd
  // indirect write: address helpers first, trigger helper last
  task automatic ind(input int t, input int v, input bit four);
    wr(CV_TGT_HUND, 8'(t / 100));
    wr(CV_TGT_UT, 8'(t % 100));
    if (four)
      wr(CV_VAL_HUND, 8'(v / 100));
    wr(CV_VAL_TRIG, four ? 8'(v % 100) : 8'(v));
  endtask : ind
  // one operating command; answer read once the taking edge has settled
  task automatic cmd(input logic a, l, input logic [13:0] ad, input dcia_kind_t k,
                     output logic [4:0] r);
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b1;
    o_cmd_alt <= a;
    o_cmd_long <= l;
    o_cmd_addr <= ad;
    o_cmd_kind <= k;
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b0;
    o_cmd_addr <= ~ad;
    #1;
    r = i_cmd_resp;
  endtask : cmd
endmodule : dcia_station
`default_nettype wire

// File: tb/test_decoder_cv_indirect_address.sv
`timescale 1ns/1ps
`default_nettype none
module test_decoder_cv_indirect_address;
  import dcia_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cv_wr, cv_rd, cv_rvalid, cmd_valid, cmd_alt, cmd_long, hit, spd, fnc, long_mode;
  logic [9:0] cv_num;
  logic [7:0] cv_wdata, cv_rdata;
  logic [13:0] cmd_addr, dcc_addr;
  logic [1:0] bank;
  dcia_kind_t cmd_kind;
  int err_count = 0;
  int n_tests = 0;
  int seed = 32'h6090;
  // addressing shadows with their values after reset, and the command kinds
  logic [9:0] rn[5] = '{CV_SHORT, CV_LONG_HI, CV_LONG_LO, CV_CONFIG, CV_CONSEC};
  logic [7:0] rv[5] = '{RST_SHORT, RST_LONG_HI, RST_LONG_LO, RST_CONFIG, RST_CONSEC};
  dcia_kind_t kd[3] = '{DCIA_K_SPEED, DCIA_K_FUNC, DCIA_K_OTHER};
  dcia_core #(.AW(10)) u_dcia_core (.i_clk_sys(clk), .i_rstn(rstn), .i_cv_wr(cv_wr),
    .i_cv_rd(cv_rd), .i_cv_num(cv_num), .i_cv_wdata(cv_wdata), .o_cv_rdata(cv_rdata),
    .o_cv_rvalid(cv_rvalid), .i_cmd_valid(cmd_valid), .i_cmd_alt(cmd_alt),
    .i_cmd_long(cmd_long), .i_cmd_addr(cmd_addr), .i_cmd_kind(cmd_kind), .o_cmd_hit(hit),
    .o_speed_take(spd), .o_func_take(fnc), .o_func_bank(bank), .o_long_mode(long_mode),
    .o_dcc_addr(dcc_addr));
  dcia_station u_dcia_station (.i_clk_sys(clk), .o_cv_wr(cv_wr), .o_cv_rd(cv_rd),
    .o_cv_num(cv_num), .o_cv_wdata(cv_wdata), .i_cv_rdata(cv_rdata), .i_cv_rvalid(cv_rvalid),
    .o_cmd_valid(cmd_valid), .o_cmd_alt(cmd_alt), .o_cmd_long(cmd_long),
    .o_cmd_addr(cmd_addr), .o_cmd_kind(cmd_kind), .i_cmd_resp({hit, spd, fnc, bank}));
  // 25 MHz system clock
  always #20 clk = ~clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // read a variable and compare, latency included
  task automatic rchk(input logic [9:0] n, input logic [7:0] e);
    logic [7:0] d;
    logic [3:0] lat;
    u_dcia_station.rd(n, d, lat);
    chk(16'(lat), 16'(RD_LATENCY));
    chk(16'(d), 16'(e));
  endtask : rchk
  // expected {hit, speed, func, bank}; bank is zero on a DCC hit and the offset on an alternate hit
  function automatic logic [4:0] exp_cmd(logic a, l, logic [13:0] ad, dcia_kind_t k,
                                         int b, logic [13:0] la, logic lm, int c);
    int off;
    off = int'(ad) - b;
    if (a) begin
      if (off < 0 || off > c)
        return 5'h00;
      return {1'b1, k == DCIA_K_SPEED && off == 0, k == DCIA_K_FUNC, 2'(off)};
    end
    if (lm ? (l && ad == la) : (!l && ad == 14'(b) && b <= 127))
      return {1'b1, k == DCIA_K_SPEED, k == DCIA_K_FUNC, 2'h0};
    return 5'h00;
  endfunction : exp_cmd
  // send a command and compare; the bank is only defined right after a hit
  task automatic cchk(logic a, l, logic [13:0] ad, dcia_kind_t k, int b, logic [13:0] la,
                      logic lm, int c);
    logic [4:0] r, e, m;
    e = exp_cmd(a, l, ad, k, b, la, lm, c);
    m = e[4] ? 5'h1f : 5'h1c;
    u_dcia_station.cmd(a, l, ad, k, r);
    chk(16'(r & m), 16'(e & m));
  endtask : cchk
  // bounded run time
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial begin
    int t, v, la;
    bit four;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'(dcc_addr), 16'h3);
    chk(16'(long_mode), 16'h0);
    for (int i = 0; i < 5; i++)
      rchk(rn[i], rv[i]);
    $display("test reset done err=%0d", err_count);
    // helper ranges: out-of-range digits are dropped
    u_dcia_station.wr(CV_TGT_HUND, 8'h0a);
    rchk(CV_TGT_HUND, 8'h00);
    u_dcia_station.wr(CV_TGT_HUND, 8'h09);
    rchk(CV_TGT_HUND, 8'h09);
    u_dcia_station.wr(CV_TGT_UT, 8'h64);
    rchk(CV_TGT_UT, 8'h00);
    u_dcia_station.wr(CV_TGT_UT, 8'h63);
    rchk(CV_TGT_UT, 8'h63);
    // random indirect copies, three- and four-helper, helpers cleared after
    u_dcia_station.ind(317, 120, 1'b1);
    rchk(10'h13d, 8'h78);
    for (int i = 0; i < 8; i++) begin
      t = 100 + ({$random(seed)} % 900);
      v = {$random(seed)} % 256;
      four = $random(seed);
      u_dcia_station.ind(t, v, four);
      rchk(10'(t), 8'(v));
      rchk(CV_TGT_HUND, 8'h00);
      rchk(CV_TGT_UT, 8'h00);
      rchk(CV_VAL_HUND, 8'h00);
      rchk(CV_VAL_TRIG, 8'h00);
    end
    // value above 255 is dropped yet helpers clear
    u_dcia_station.ind(642, 77, 1'b0);
    u_dcia_station.ind(642, 299, 1'b1);
    rchk(10'h282, 8'h4d);
    rchk(CV_VAL_HUND, 8'h00);
    rchk(CV_TGT_UT, 8'h00);
    // a copy aimed at a helper is refused, helpers still clear
    u_dcia_station.ind(97, 5, 1'b0);
    rchk(CV_TGT_UT, 8'h00);
    $display("test indirect done err=%0d", err_count);
    // long addresses, boundary first, then random
    for (int i = 0; i < 4; i++) begin
      la = (i == 0) ? 10239 : 128 + ({$random(seed)} % 10112);
      u_dcia_station.wr(CV_LONG_HI, {2'h3, 6'(la >> 8)});
      u_dcia_station.wr(CV_LONG_LO, 8'(la));
      u_dcia_station.wr(CV_CONFIG, 8'h20);
      // the address outputs follow the configuration one edge later
      @(posedge clk);
      #1;
      chk(16'(dcc_addr), 16'(la));
      chk(16'(long_mode), 16'h1);
      cchk(1'b0, 1'b1, 14'(la), kd[i % 3], 3, 14'(la), 1'b1, 0);
      cchk(1'b0, 1'b0, 14'h3, DCIA_K_FUNC, 3, 14'(la), 1'b1, 0);
      u_dcia_station.wr(CV_CONFIG, 8'h00);
      @(posedge clk);
      #1;
      chk(16'(dcc_addr), 16'h3);
      cchk(1'b0, 1'b1, 14'(la), DCIA_K_SPEED, 3, 14'(la), 1'b0, 0);
      cchk(1'b0, 1'b0, 14'h3, kd[i % 3], 3, 14'(la), 1'b0, 0);
    end
    // short cap and refused zero
    u_dcia_station.wr(CV_SHORT, 8'h7f);
    cchk(1'b0, 1'b0, 14'h7f, DCIA_K_SPEED, 127, 14'h0, 1'b0, 0);
    u_dcia_station.wr(CV_SHORT, 8'h80);
    cchk(1'b0, 1'b0, 14'h80, DCIA_K_SPEED, 128, 14'h0, 1'b0, 0);
    u_dcia_station.wr(CV_SHORT, 8'h00);
    rchk(CV_SHORT, 8'h80);
    $display("test address done err=%0d", err_count);
    // alternate format: every consecutive count, every offset and kind
    u_dcia_station.wr(CV_SHORT, 8'h32);
    for (int c = 0; c < 4; c++) begin
      u_dcia_station.wr(CV_CONSEC, {c[1], 3'h0, c[0], 3'h1});
      for (int o = 0; o < 5; o++)
        for (int k = 0; k < 3; k++)
          cchk(1'b1, 1'b0, 14'(50 + o), kd[k], 50, 14'h0, 1'b0, c);
      cchk(1'b0, 1'b0, 14'h33, DCIA_K_FUNC, 50, 14'h0, 1'b0, c);
      cchk(1'b0, 1'b0, 14'h32, DCIA_K_FUNC, 50, 14'h0, 1'b0, c);
    end
    $display("test alternate done err=%0d", err_count);
    end_sim();
  end
endmodule : test_decoder_cv_indirect_address
`default_nettype wire
